//--- device_control_status.v
// control/status word with software-trigger engine, interrupts and store handshake
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "ctrl_status_regs.vh"

module device_control_status (
	input  wire        clk_in,
	input  wire        reset_n_in,
	input  wire [3:0]  addr_in,
	input  wire [15:0] wdata_in,
	input  wire        wr_in,
	input  wire        rd_in,
	output reg  [15:0] rdata_out,
	input  wire [4:0]  trigger_input_levels_in,
	input  wire        interlock_open_in,
	output wire        module_reset_n_out,
	output wire        osc_gate_out,
	output wire        pulser_gate_out,
	output wire        dither_off_out,
	output reg         soft_engine_out_level_out,
	output reg         store_save_req_out,
	input  wire        store_save_done_in,
	output reg         store_load_req_out,
	input  wire        store_load_done_in,
	input  wire [7:0]  store_load_data_in,
	output wire [7:0]  store_save_data_out,
	output reg         restart_out,
	output wire        irq_out
);

	// ************************************************************
	// input synchronisers
	// ************************************************************
	reg  [5:0]  sync_a;
	reg  [5:0]  sync_b;
	reg  [5:0]  sync_prev;
	wire [4:0]  trig_lvl  = sync_b[4:0];
	wire        ilock     = sync_b[5];

	// two flops before any logic; prev feeds the change detectors only
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync_a    <= 6'h00;
			sync_b    <= 6'h00;
			sync_prev <= 6'h00;
		end else begin
			sync_a    <= {interlock_open_in, trigger_input_levels_in};
			sync_b    <= sync_a;
			sync_prev <= sync_b;
		end
	end

	// ************************************************************
	// restart sequencer: save, pulse restart, reload
	// ************************************************************
	localparam ST_IDLE    = 2'h0;
	localparam ST_SAVE    = 2'h1;
	localparam ST_RESTART = 2'h2;
	localparam ST_LOAD    = 2'h3;

	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [7:0]  control;
	reg         restore_done;
	wire        wr_ctrl = wr_in && (addr_in == `ADDR_CONTROL_STATUS);
	wire        wr_rst  = wr_in && (addr_in == `ADDR_RESTART);

	// the word under save is the live control byte
	assign store_save_data_out = control;

	// next state: restart only taken from idle so a save is never cut short
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE:    if (wr_rst) next_state = ST_SAVE;
			ST_SAVE:    if (store_save_done_in) next_state = ST_RESTART; // R14
			ST_RESTART: next_state = ST_LOAD;
			ST_LOAD:    if (store_load_done_in) next_state = ST_IDLE; // R15
			default:    next_state = ST_IDLE;
		endcase
	end

	// sequencer registers and strobes
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state              <= ST_IDLE;
			store_save_req_out <= 1'b0;
			store_load_req_out <= 1'b0;
			restart_out        <= 1'b0;
			restore_done       <= 1'b0;
		end else begin
			state              <= next_state;
			store_save_req_out <= (next_state == ST_SAVE); // R14
			restart_out        <= (next_state == ST_RESTART);
			store_load_req_out <= (next_state == ST_LOAD); // R15
			restore_done       <= (state == ST_LOAD) && store_load_done_in;
		end
	end

	// ************************************************************
	// control byte
	// ************************************************************
	// host writes blocked while the sequencer owns the byte
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			control <= `CONTROL_RESET;
		end else if ((state == ST_LOAD) && store_load_done_in) begin
			control <= store_load_data_in & `CONTROL_WMASK; // R15
		end else if (wr_ctrl && (state == ST_IDLE)) begin
			control <= wdata_in[7:0] & `CONTROL_WMASK; // R01
		end
	end

	wire lvl_req = control[`BIT_LEVEL_REQUEST];  // R08
	wire stb_req = control[`BIT_STROBE_REQUEST]; // R08

	// R04 R05: bypass masks the interlock, run bit always acts
	assign module_reset_n_out = control[`BIT_DEVICE_RUN] &
		(control[`BIT_IRQ_BYPASS] | ~ilock);
	assign osc_gate_out    = control[`BIT_OSCILLATOR_RUN]; // R13
	assign pulser_gate_out = control[`BIT_PULSER_RUN];     // R13
	assign dither_off_out  = control[`BIT_DITHER_OFF];     // R12

	// ************************************************************
	// software-trigger engine
	// ************************************************************
	reg stb_prev;
	// edge of the strobe request gives one clock; xor flips the level for it
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stb_prev                  <= 1'b0;
			soft_engine_out_level_out <= 1'b0;
		end else begin
			stb_prev                  <= stb_req;
			soft_engine_out_level_out <= lvl_req ^ (stb_req & ~stb_prev); // R16 R09 R10 R11
		end
	end

	// ************************************************************
	// interrupts
	// ************************************************************
	reg  [3:0] irq_status;
	reg  [3:0] irq_mask;
	reg        eng_prev;
	wire [3:0] irq_event;
	wire       rd_irq = rd_in && (addr_in == `ADDR_IRQ_STATUS);

	assign irq_event[`IRQ_TRIG_CHANGE]      = |(trig_lvl ^ sync_prev[4:0]);
	assign irq_event[`IRQ_INTERLOCK_CHANGE] = ilock ^ sync_prev[5];
	assign irq_event[`IRQ_RESTORE_DONE]     = restore_done;
	assign irq_event[`IRQ_ENGINE_RISE]      = soft_engine_out_level_out & ~eng_prev;

	localparam [3:0] IRQ_INIT = `IRQ_RESET;

	// engine history for the rise detector
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			eng_prev <= 1'b0;
		end else begin
			eng_prev <= soft_engine_out_level_out;
		end
	end

	// mask register, same layout as the status bits
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_mask <= `IRQ_RESET;
		end else if (wr_in && (addr_in == `ADDR_IRQ_MASK)) begin
			irq_mask <= wdata_in[3:0];
		end
	end

	// one sticky bit per event; read clears, but a same-cycle event wins
	// so that no event is lost between the read and the clear
	genvar n;
	generate
		for (n = 0; n < 4; n = n + 1) begin : g_irq_bit
			always @(posedge clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					irq_status[n] <= IRQ_INIT[n];
				end else if (irq_event[n]) begin
					irq_status[n] <= 1'b1;
				end else if (rd_irq) begin
					irq_status[n] <= 1'b0;
				end
			end
		end
	endgenerate

	assign irq_out = |(irq_status & irq_mask);

	// ************************************************************
	// read port
	// ************************************************************
	reg [15:0] next_rdata;

	// status byte is rebuilt live; writes to it have nowhere to land
	always @* begin
		next_rdata = 16'h0000;
		if (rd_in) begin
			case (addr_in)
				`ADDR_CONTROL_STATUS: begin
					next_rdata = {trig_lvl, // R02
						ilock,                      // R06
						module_reset_n_out,         // R03
						soft_engine_out_level_out,  // R07
						control};                   // R01
				end
				`ADDR_IRQ_STATUS: begin
					next_rdata = {12'h000, irq_status};
				end
				`ADDR_IRQ_MASK: begin
					next_rdata = {12'h000, irq_mask};
				end
				`ADDR_RESTART: begin
					next_rdata = {14'h0000, state};
				end
				default: begin
					next_rdata = 16'h0000;
				end
			endcase
		end
	end

	// data stand one cycle after the strobe and read zero otherwise
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_out <= 16'h0000;
		end else begin
			rdata_out <= next_rdata;
		end
	end

endmodule // device_control_status

//--- ctrl_status_regs.vh
// register offsets, field positions and reset values for the control/status word
//
// What this block does
// R01: only low byte writable, bit 5 excepted; high byte is status
// R02: bits 11-15 show trigger input levels
// R03: bit 9 shows active-low module reset
// R04: reset when run clear, or interlock open with bypass clear
// R05: bypass set makes interlock irrelevant
// R06: bit 10 mirrors interlock open
// R07: bit 8 shows engine output level
// R08: bit 3 level request, bit 4 strobe
// R09: strobe low: output follows level request
// R10: strobe pulse, level low: one-clock high pulse
// R11: strobe pulse, level high: one-clock low pulse
// R12: bit 6 clear enables supply dithering
// R13: bit 1 oscillator gate, bit 2 pulser gate
// R14: restart first saves configuration to store
// R15: after restart reload configuration from store
// R16: output is level xor registered strobe edge
`ifndef CTRL_STATUS_REGS_VH
`define CTRL_STATUS_REGS_VH

// ************************************************************
// register map
// ************************************************************
`define ADDR_CONTROL_STATUS  4'h0
`define ADDR_IRQ_STATUS      4'h1
`define ADDR_IRQ_MASK        4'h2
`define ADDR_RESTART         4'h3

// ************************************************************
// field positions of the control/status word
// ************************************************************
`define BIT_DEVICE_RUN       0
`define BIT_OSCILLATOR_RUN   1
`define BIT_PULSER_RUN       2
`define BIT_LEVEL_REQUEST    3
`define BIT_STROBE_REQUEST   4
`define BIT_DITHER_OFF       6
`define BIT_IRQ_BYPASS       7
`define BIT_ENGINE_OUT       8
`define BIT_MODULE_RESET_N   9
`define BIT_INTERLOCK_OPEN   10
`define BIT_TRIG_LO          11

// ************************************************************
// reset values and interrupt event bits
// ************************************************************
`define CONTROL_RESET        8'h00
`define CONTROL_WMASK        8'hdf
`define IRQ_RESET            4'h0
`define IRQ_TRIG_CHANGE      0
`define IRQ_INTERLOCK_CHANGE 1
`define IRQ_RESTORE_DONE     2
`define IRQ_ENGINE_RISE      3

`endif

//--- device_control_status_props.sv
// assertion checker bound to the control/status word
`timescale 1ns/1ns
`include "ctrl_status_regs.vh"
module device_control_status_props (
	input wire logic        clk_in,
	input wire logic        reset_n_in,
	input wire logic [3:0]  addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [15:0] rdata_out,
	input wire logic        module_reset_n_out,
	input wire logic        osc_gate_out,
	input wire logic        pulser_gate_out,
	input wire logic        dither_off_out,
	input wire logic        soft_engine_out_level_out,
	input wire logic        store_save_req_out,
	input wire logic        store_save_done_in,
	input wire logic        store_load_req_out,
	input wire logic        store_load_done_in,
	input wire logic [7:0]  store_load_data_in,
	input wire logic [7:0]  store_save_data_out,
	input wire logic        restart_out
);
	// ****
	// helper: sequencer idle and last strobe bit
	// ****
	wire  idle = !store_save_req_out && !store_load_req_out && !restart_out;
	wire  ctrl_wr = wr_in && addr_in == `ADDR_CONTROL_STATUS && idle; // plain flag for mixing
	logic strobe_q; // a held strobe must not count as a fresh edge
	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
			strobe_q <= 1'b0;
		else if (wr_in && addr_in == `ADDR_CONTROL_STATUS && idle)
			strobe_q <= wdata_in[4];
		else if (store_load_req_out && store_load_done_in)
			strobe_q <= store_load_data_in[4];
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence ctrl_wr_s; wr_in && addr_in == `ADDR_CONTROL_STATUS && idle; endsequence
	sequence save_end_s; store_save_req_out && store_save_done_in; endsequence
	a_gate_write: assert property (ctrl_wr_s |=> osc_gate_out == $past(wdata_in[1]) &&
		pulser_gate_out == $past(wdata_in[2]) && dither_off_out == $past(wdata_in[6]))
		else $error("gate outputs differ from written bits");
	a_run_off: assert property (ctrl_wr && !wdata_in[0] |=> !module_reset_n_out)
		else $error("module reset not held with run cleared");
	a_bypass_run: assert property (ctrl_wr && wdata_in[0] && wdata_in[7] |=> module_reset_n_out)
		else $error("module reset held despite bypass");
	a_read_status: assert property (rd_in && addr_in == `ADDR_CONTROL_STATUS |=>
		rdata_out[9:8] == {$past(module_reset_n_out), $past(soft_engine_out_level_out)})
		else $error("status bits 9:8 wrong");
	a_level_follow: assert property (ctrl_wr && !wdata_in[4] ##1 !wr_in |=>
		soft_engine_out_level_out == $past(wdata_in[3], 2)) else $error("engine not following level");
	a_strobe_pulse: assert property (ctrl_wr && wdata_in[4] && !strobe_q ##1 !wr_in |=>
		soft_engine_out_level_out == !$past(wdata_in[3], 2) ##1
		soft_engine_out_level_out == $past(wdata_in[3], 3)) else $error("strobe pulse wrong");
	a_restart_save: assert property (wr_in && addr_in == `ADDR_RESTART && idle |=> store_save_req_out)
		else $error("restart did not start save");
	a_save_restart: assert property (save_end_s |=> !store_save_req_out && restart_out ##1
		store_load_req_out && !restart_out) else $error("restart sequence wrong");
	a_load_restore: assert property (store_load_req_out && store_load_done_in |=> !store_load_req_out &&
		{dither_off_out, pulser_gate_out, osc_gate_out} ==
		{$past(store_load_data_in[6]), $past(store_load_data_in[2:1])}) else $error("restore wrong");
	a_save_image: assert property (store_save_req_out |-> store_save_data_out[6] == dither_off_out &&
		store_save_data_out[2:1] == {pulser_gate_out, osc_gate_out}) else $error("saved image wrong");
endmodule // device_control_status_props

bind device_control_status device_control_status_props device_control_status_props_i (.*);

//--- test_device_control_status.sv
// self-checking bench for the control/status word
`timescale 1ns/1ns
`include "ctrl_status_regs.vh"
module test_device_control_status;
	logic        clk_in, reset_n_in, wr_in, rd_in, interlock_open_in, irq_out, restart_out, il;
	logic        store_save_done_in, store_load_done_in, store_save_req_out, store_load_req_out;
	logic        module_reset_n_out, osc_gate_out, pulser_gate_out, dither_off_out;
	logic        soft_engine_out_level_out;
	logic [3:0]  addr_in;
	logic [4:0]  trigger_input_levels_in, t;
	logic [7:0]  store_load_data_in, store_save_data_out;
	logic [15:0] wdata_in, rdata_out, rv, d, e;
	integer      seed, mismatches, comparisons, i, l;
	logic [15:0] corner [4] = '{16'hff00, 16'h0001, 16'h0081, 16'h00ff};
	device_control_status device_control_status_i (.*);
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] v);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input logic [3:0] a);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		rv = rdata_out;
		@(posedge clk_in);
	endtask
	function logic [15:0] expw(input logic [7:0] c, input logic [4:0] tr, input logic lk);
		return {tr, lk, c[0] & (c[7] | !lk), c[3], c & 8'hdf};
	endfunction
	task final_report;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk_in);
		mismatches++;
		final_report;
	end
	initial begin
		{seed, mismatches, comparisons} = {32'd95771, 64'd0};
		{reset_n_in, wr_in, rd_in, interlock_open_in, store_save_done_in, store_load_done_in} = 0;
		{addr_in, wdata_in, trigger_input_levels_in, store_load_data_in} = 0;
		repeat (2) @(posedge clk_in);
		reset_n_in <= 1'b1;
		rd(`ADDR_CONTROL_STATUS);
		chk(rv, 0, "reset word");
		// corners first, then random words, levels and interlock
		for (i = 0; i < 20; i++) begin
			d = (i < 4) ? corner[i] : 16'($random(seed));
			t = 5'($random(seed));
			il = (i < 4) ? 1'b1 : 1'($random(seed));
			trigger_input_levels_in <= t;
			interlock_open_in <= il;
			wr(`ADDR_CONTROL_STATUS, d);
			repeat (2) @(posedge clk_in);
			rd(`ADDR_CONTROL_STATUS);
			e = expw(d[7:0], t, il);
			chk({rv, module_reset_n_out, osc_gate_out, pulser_gate_out, dither_off_out}, {e, e[9], d[1], d[2], d[6]}, "word");
		end
		$display("test control word done");
		for (l = 0; l < 2; l++) begin
			wr(`ADDR_CONTROL_STATUS, 16'(l * 8 + 1));
			wr(`ADDR_CONTROL_STATUS, 16'(l * 8 + 17));
			@(negedge clk_in);
			chk(soft_engine_out_level_out, l == 0, "pulse");
			@(negedge clk_in);
			chk(soft_engine_out_level_out, l == 1, "after pulse");
			@(posedge clk_in);
			wr(`ADDR_CONTROL_STATUS, 16'(l * 8 + 1));
			repeat (2) @(negedge clk_in);
			chk(soft_engine_out_level_out, l == 1, "strobe release");
			@(posedge clk_in);
		end
		$display("test engine done");
		rd(`ADDR_IRQ_STATUS);
		wr(`ADDR_IRQ_MASK, 0);
		wr(`ADDR_CONTROL_STATUS, 16'h0001);
		wr(`ADDR_CONTROL_STATUS, 16'h0009);
		repeat (3) @(negedge clk_in);
		chk(irq_out, 0, "masked irq");
		@(posedge clk_in);
		wr(`ADDR_IRQ_MASK, 16'h0008);
		@(negedge clk_in);
		chk(irq_out, 1, "irq");
		@(posedge clk_in);
		rd(`ADDR_IRQ_STATUS);
		chk({rv[3], irq_out}, 2'b10, "irq status");
		rd(`ADDR_IRQ_STATUS);
		rd(4'h9);
		chk(rv, 0, "unmapped");
		$display("test interrupts done");
		wr(`ADDR_CONTROL_STATUS, 16'h0046);
		wr(`ADDR_RESTART, 0);
		@(negedge clk_in);
		chk({store_save_req_out, store_save_data_out}, 9'h146, "save");
		@(posedge clk_in);
		store_save_done_in <= 1'b1;
		@(posedge clk_in);
		store_save_done_in <= 1'b0;
		for (i = 0; i < 20 && store_load_req_out !== 1'b1; i++)
			@(negedge clk_in);
		chk(store_load_req_out, 1, "load request");
		@(posedge clk_in);
		store_load_data_in <= 8'h25;
		store_load_done_in <= 1'b1;
		@(posedge clk_in);
		store_load_done_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rd(`ADDR_CONTROL_STATUS);
		chk(rv[7:0], 8'h05, "restored byte");
		rd(`ADDR_IRQ_STATUS);
		chk(rv[2], 1, "restore event");
		$display("test restart done");
		final_report;
	end
endmodule // test_device_control_status
